// [rtl/fbspi_regs.vh]
`ifndef FBSPI_REGS_VH
`define FBSPI_REGS_VH

// register byte offsets
`define FBSPI_OFS_INIT      12'h000
`define FBSPI_OFS_STATUS    12'h004
`define FBSPI_OFS_PRMINFO   12'h008
`define FBSPI_OFS_IDENT     12'h00c
`define FBSPI_OFS_UPRM0     12'h010
`define FBSPI_OFS_UPRM1     12'h014
`define FBSPI_PAGE_IN       4'h1
`define FBSPI_PAGE_OUT      4'h2
`define FBSPI_IMG_WORDS     6'h3c

// image geometry: 240 bytes, 30 groups of 8 bytes
`define FBSPI_IMG_GROUPS    5'h1e
`define FBSPI_MAX_LEN       8'hf0
`define FBSPI_MAX_ADDR      7'h7d
`define FBSPI_GRP_LAST      3'h7

// initialisation status values
`define FBSPI_INIT_BUSY     8'h00
`define FBSPI_INIT_BADADDR  8'h01
`define FBSPI_INIT_BADLEN   8'h02
`define FBSPI_INIT_DONE     8'hff

// bus status values
`define FBSPI_BS_WAITINIT   8'h00
`define FBSPI_BS_WAITPRM    8'h01
`define FBSPI_BS_WDERR      8'h04
`define FBSPI_BS_PHYERR     8'h05
`define FBSPI_BS_CFGERR     8'h07
`define FBSPI_BS_PRMERR     8'h08
`define FBSPI_BS_RUN        8'hff

// frame kinds on the link
`define FBSPI_KIND_DATA     2'h0
`define FBSPI_KIND_PRM      2'h1
`define FBSPI_KIND_CFG      2'h2

// parameter octet positions (1-based) and limits
`define FBSPI_OCT_STATUS    5'h01
`define FBSPI_OCT_WDF1      5'h02
`define FBSPI_OCT_WDF2      5'h03
`define FBSPI_OCT_TSDR      5'h04
`define FBSPI_OCT_IDHI      5'h05
`define FBSPI_OCT_IDLO      5'h06
`define FBSPI_OCT_USER0     5'h08
`define FBSPI_OCT_LAST      5'h0f
`define FBSPI_WD_ON_BIT     3
`define FBSPI_TSDR_DEFAULT  8'h0b

// timing
`define FBSPI_CLK_NS        5
`define FBSPI_MS_NS         1000000
`define FBSPI_WD_UNIT_MS    4'ha

`endif

// [rtl/fbspi_top.v]
`timescale 1ns/1ps
`include "fbspi_regs.vh"

module fbspi_top #(
	parameter MS_CYCLES = `FBSPI_MS_NS / `FBSPI_CLK_NS
) (
	input  wire        clock_i,
	input  wire        rst_n_i,
	input  wire [11:0] paddr_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	input  wire        rx_valid_i,
	input  wire [7:0]  rx_byte_i,
	input  wire        rx_first_i,
	input  wire        rx_last_i,
	input  wire [1:0]  rx_kind_i,
	output wire        rx_ready_o,
	output wire        tx_valid_o,
	output wire [7:0]  tx_byte_o,
	output wire        tx_last_o,
	input  wire        tx_ready_i,
	input  wire        phy_err_i,
	output wire [6:0]  station_addr_o,
	output wire        bus_enable_o,
	output reg         user_irq_o,
	output wire        prm_valid_o
);
	localparam S_IDLE   = 3'h0;
	localparam S_RXD    = 3'h1;
	localparam S_TSDR   = 3'h2;
	localparam S_TX     = 3'h3;
	localparam S_COMMIT = 3'h4;
	localparam S_PRM    = 3'h5;
	localparam S_CFG    = 3'h6;

	reg        rs1_reg, rs2_reg;
	wire       rst_n = rs2_reg;
	reg [63:0] in_img  [0:29];
	reg [63:0] out_img [0:29];
	reg [63:0] pend    [0:29];
	reg [31:0] init_reg, hold_lo_reg, snap_reg;
	reg        init_pend_reg;
	reg [7:0]  init_stat_reg, bus_stat_reg;
	reg [7:0]  oct1_reg, wdf1_reg, wdf2_reg, tsdr_reg;
	reg [15:0] ident_reg;
	reg [63:0] uprm_reg, asm_reg, txsh_reg;
	reg [2:0]  st_reg;
	reg [7:0]  cnt_reg, tsdr_cnt_reg, cfg_in_reg;
	reg [4:0]  grp_reg;
	reg [17:0] ms_cnt_reg;
	reg [3:0]  wd_ms_reg;
	reg [15:0] wd_units_reg;
	reg [7:0]  irq_ms_reg;
	reg        irq_pend_reg;
	integer    k;

	// rounded lengths expressed as 8-byte groups
	wire [6:0] st_addr  = init_reg[6:0];
	wire [7:0] input_image_length   = init_reg[15:8];
	wire [7:0] output_image_length  = init_reg[23:16];
	wire [7:0] period   = init_reg[31:24];
	wire [8:0] in_sum   = {1'b0, input_image_length} + 9'h007;
	wire [8:0] out_sum  = {1'b0, output_image_length} + 9'h007;
	wire [4:0] in_grps  = in_sum[7:3];
	wire [4:0] out_grps = out_sum[7:3];
	wire       running  = bus_stat_reg == `FBSPI_BS_RUN;

	// apb decode; zero wait states, prdata loaded in setup phase
	wire       setup  = psel_i & ~penable_i;
	wire       access = psel_i & penable_i;
	wire [3:0] page   = paddr_i[11:8];
	wire [5:0] widx   = paddr_i[7:2];
	wire [4:0] wgrp   = widx[5:1];
	wire       is_img = (page == `FBSPI_PAGE_IN || page == `FBSPI_PAGE_OUT)
	                    && widx < `FBSPI_IMG_WORDS && paddr_i[1:0] == 2'h0;
	wire       is_reg = paddr_i == `FBSPI_OFS_INIT ||
	                    paddr_i == `FBSPI_OFS_STATUS ||
	                    paddr_i == `FBSPI_OFS_PRMINFO ||
	                    paddr_i == `FBSPI_OFS_IDENT ||
	                    paddr_i == `FBSPI_OFS_UPRM0 ||
	                    paddr_i == `FBSPI_OFS_UPRM1;
	wire       wr_ok  = paddr_i == `FBSPI_OFS_INIT ||
	                    (is_img && page == `FBSPI_PAGE_OUT);
	wire       bad    = ~(is_img | is_reg) | (pwrite_i & ~wr_ok);
	wire       wr     = access & pwrite_i & ~bad;
	assign pready_o  = 1'b1;
	assign pslverr_o = access & bad;

	// status outputs
	assign station_addr_o = st_addr;
	assign bus_enable_o   = bus_stat_reg != `FBSPI_BS_WAITINIT;
	assign prm_valid_o    = bus_stat_reg == `FBSPI_BS_WDERR ||
	                        bus_stat_reg == `FBSPI_BS_CFGERR || running;
	// an opening byte is left standing in idle so its own state takes it
	wire   frm_start      = rx_valid_i && rx_first_i && bus_enable_o &&
	                        (rx_kind_i == `FBSPI_KIND_PRM ||
	                         rx_kind_i == `FBSPI_KIND_CFG || running);
	assign rx_ready_o     = (st_reg == S_IDLE && !frm_start) ||
	                        st_reg == S_RXD ||
	                        st_reg == S_PRM || st_reg == S_CFG;
	assign tx_valid_o     = st_reg == S_TX;
	assign tx_byte_o      = txsh_reg[7:0];
	assign tx_last_o      = st_reg == S_TX && grp_reg == out_grps - 5'h01
	                        && cnt_reg[2:0] == `FBSPI_GRP_LAST;

	wire       rx_take  = rx_valid_i & rx_ready_o;
	wire       tx_take  = tx_valid_o & tx_ready_i;
	wire [31:0] ms_last = MS_CYCLES - 1;
	wire       ms_tick  = {14'h0000, ms_cnt_reg} == ms_last;
	wire [15:0] wd_lim  = wdf1_reg * wdf2_reg;

	// reset release through two flops
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rs1_reg <= 1'b0;
			rs2_reg <= 1'b0;
		end else begin
			rs1_reg <= 1'b1;
			rs2_reg <= rs1_reg;
		end
	end

	// read data; reading the low word of an input group latches its
	// high word so software sees the eight bytes from one commit
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_o <= 32'h0000_0000;
			snap_reg <= 32'h0000_0000;
		end else if (setup && !pwrite_i) begin
			prdata_o <= 32'h0000_0000;
			if (is_img && page == `FBSPI_PAGE_IN) begin
				if (!widx[0]) begin
					prdata_o <= in_img[wgrp][31:0];
					snap_reg <= in_img[wgrp][63:32];
				end else begin
					prdata_o <= snap_reg;
				end
			end else if (is_img) begin
				prdata_o <= widx[0] ? out_img[wgrp][63:32]
				                    : out_img[wgrp][31:0];
			end else begin
				case (paddr_i)
				`FBSPI_OFS_INIT:    prdata_o <= init_reg;
				`FBSPI_OFS_STATUS:  prdata_o <= {15'h0000, prm_valid_o,
				                                 bus_stat_reg, init_stat_reg};
				`FBSPI_OFS_PRMINFO: prdata_o <= {oct1_reg, wdf2_reg,
				                                 wdf1_reg, tsdr_reg};
				`FBSPI_OFS_IDENT:   prdata_o <= {16'h0000, ident_reg};
				`FBSPI_OFS_UPRM0:   prdata_o <= uprm_reg[31:0];
				`FBSPI_OFS_UPRM1:   prdata_o <= uprm_reg[63:32];
				default:            prdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// output image writes: low word parks, high word commits the group
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			hold_lo_reg <= 32'h0000_0000;
			for (k = 0; k < 30; k = k + 1)
				out_img[k] <= 64'h0;
		end else if (wr && page == `FBSPI_PAGE_OUT && is_img) begin
			if (!widx[0])
				hold_lo_reg <= pwdata_i;
			else
				out_img[wgrp] <= {pwdata_i, hold_lo_reg};
		end
	end

	// initialisation: write to INIT shows 0 for one cycle, then result
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			init_reg      <= 32'h0000_0000;
			init_pend_reg <= 1'b0;
			init_stat_reg <= `FBSPI_INIT_BUSY;
		end else if (wr && paddr_i == `FBSPI_OFS_INIT) begin
			init_reg      <= pwdata_i;
			init_pend_reg <= 1'b1;
			init_stat_reg <= `FBSPI_INIT_BUSY;
		end else if (init_pend_reg) begin
			init_pend_reg <= 1'b0;
			if (init_reg[7:0] > {1'b0, `FBSPI_MAX_ADDR})
				init_stat_reg <= `FBSPI_INIT_BADADDR;
			else if (input_image_length > `FBSPI_MAX_LEN || output_image_length > `FBSPI_MAX_LEN)
				init_stat_reg <= `FBSPI_INIT_BADLEN;
			else
				init_stat_reg <= `FBSPI_INIT_DONE;
		end
	end

	// millisecond tick shared by watchdog and interrupt pacing
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n)
			ms_cnt_reg <= 18'h00000;
		else if (init_pend_reg || ms_tick)
			ms_cnt_reg <= 18'h00000;
		else
			ms_cnt_reg <= ms_cnt_reg + 18'h00001;
	end

	// frame engine and bus status
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			st_reg       <= S_IDLE;
			bus_stat_reg <= `FBSPI_BS_WAITINIT;
			cnt_reg      <= 8'h00;
			grp_reg      <= 5'h00;
			tsdr_cnt_reg <= 8'h00;
			cfg_in_reg   <= 8'h00;
			asm_reg      <= 64'h0;
			txsh_reg     <= 64'h0;
			oct1_reg     <= 8'h00;
			wdf1_reg     <= 8'h01;
			wdf2_reg     <= 8'h01;
			tsdr_reg     <= `FBSPI_TSDR_DEFAULT;
			ident_reg    <= 16'h0000;
			uprm_reg     <= 64'h0;
			wd_ms_reg    <= 4'h0;
			wd_units_reg <= 16'h0000;
			irq_pend_reg <= 1'b0;
			for (k = 0; k < 30; k = k + 1) begin
				in_img[k] <= 64'h0;
				pend[k]   <= 64'h0;
			end
		end else if (init_pend_reg) begin
			// re-init drops any frame in flight and clears timers
			st_reg       <= S_IDLE;
			wd_ms_reg    <= 4'h0;
			wd_units_reg <= 16'h0000;
			irq_pend_reg <= 1'b0;
			bus_stat_reg <= `FBSPI_BS_WAITINIT;
		end else begin
			if (init_stat_reg == `FBSPI_INIT_DONE &&
			    bus_stat_reg == `FBSPI_BS_WAITINIT)
				bus_stat_reg <= `FBSPI_BS_WAITPRM;
			if (phy_err_i && bus_enable_o)
				bus_stat_reg <= `FBSPI_BS_PHYERR;
			// watchdog runs only while exchanging data
			if (running && oct1_reg[`FBSPI_WD_ON_BIT]) begin
				if (ms_tick) begin
					if (wd_ms_reg == `FBSPI_WD_UNIT_MS - 4'h1) begin
						wd_ms_reg    <= 4'h0;
						wd_units_reg <= wd_units_reg + 16'h0001;
					end else begin
						wd_ms_reg <= wd_ms_reg + 4'h1;
					end
				end
				if (wd_units_reg >= wd_lim)
					bus_stat_reg <= `FBSPI_BS_WDERR;
			end
			if (user_irq_o)
				irq_pend_reg <= 1'b0;
			case (st_reg)
			S_IDLE: begin
				// opening byte not taken here; short frames read as zero
				if (frm_start) begin
					cnt_reg <= 8'h00;
					asm_reg <= 64'h0;
					for (k = 0; k < 30; k = k + 1)
						pend[k] <= 64'h0;
					if (rx_kind_i == `FBSPI_KIND_PRM)
						st_reg <= S_PRM;
					else if (rx_kind_i == `FBSPI_KIND_CFG)
						st_reg <= S_CFG;
					else begin
						st_reg       <= S_RXD;
						wd_ms_reg    <= 4'h0;
						wd_units_reg <= 16'h0000;
					end
				end
			end
			S_RXD: begin
				// bytes beyond the input length rounded up to whole groups are dropped
				if (rx_take) begin
					cnt_reg <= cnt_reg + 8'h01;
					if (cnt_reg < {in_grps, 3'h0}) begin
						asm_reg[{cnt_reg[2:0], 3'h0} +: 8] <= rx_byte_i;
						if (cnt_reg[2:0] == `FBSPI_GRP_LAST || rx_last_i)
							pend[cnt_reg[7:3]] <= asm_reg |
							    ({56'h0, rx_byte_i} << {cnt_reg[2:0], 3'h0});
						if (cnt_reg[2:0] == `FBSPI_GRP_LAST)
							asm_reg <= 64'h0;
					end
					if (rx_last_i) begin
						st_reg       <= S_TSDR;
						tsdr_cnt_reg <= 8'h00;
					end
				end
			end
			S_TSDR: begin
				// hold off the response for the minimum delay
				tsdr_cnt_reg <= tsdr_cnt_reg + 8'h01;
				if (tsdr_cnt_reg >= tsdr_reg) begin
					grp_reg  <= 5'h00;
					cnt_reg  <= 8'h00;
					txsh_reg <= out_img[0];
					st_reg   <= (out_grps == 5'h00) ? S_COMMIT : S_TX;
				end
			end
			S_TX: begin
				if (tx_take) begin
					cnt_reg  <= cnt_reg + 8'h01;
					txsh_reg <= txsh_reg >> 8;
					if (cnt_reg[2:0] == `FBSPI_GRP_LAST) begin
						grp_reg  <= grp_reg + 5'h01;
						txsh_reg <= out_img[grp_reg + 5'h01];
						if (tx_last_o) begin
							grp_reg <= 5'h00;
							st_reg  <= S_COMMIT;
						end
					end
				end
			end
			S_COMMIT: begin
				// one whole group per cycle, after the response
				if (grp_reg < in_grps)
					in_img[grp_reg] <= pend[grp_reg];
				grp_reg <= grp_reg + 5'h01;
				if (grp_reg + 5'h01 >= in_grps) begin
					irq_pend_reg <= 1'b1;
					st_reg       <= S_IDLE;
				end
			end
			S_PRM: begin
				if (rx_take) begin
					cnt_reg <= cnt_reg + 8'h01;
					case (cnt_reg[4:0] + 5'h01)
					`FBSPI_OCT_STATUS: oct1_reg <= rx_byte_i;
					`FBSPI_OCT_WDF1:   wdf1_reg <= rx_byte_i;
					`FBSPI_OCT_WDF2:   wdf2_reg <= rx_byte_i;
					`FBSPI_OCT_TSDR:
						if (rx_byte_i != 8'h00)
							tsdr_reg <= rx_byte_i;
					`FBSPI_OCT_IDHI:   ident_reg[15:8] <= rx_byte_i;
					`FBSPI_OCT_IDLO:   ident_reg[7:0]  <= rx_byte_i;
					default:
						if (cnt_reg >= {3'h0, `FBSPI_OCT_USER0 - 5'h01} &&
						    cnt_reg < {3'h0, `FBSPI_OCT_LAST})
							uprm_reg[{cnt_reg[2:0] + 3'h1, 3'h0} +: 8]
							    <= rx_byte_i;
					endcase
					if (rx_last_i) begin
						st_reg <= S_IDLE;
						if (cnt_reg >= {3'h0, `FBSPI_OCT_LAST})
							bus_stat_reg <= `FBSPI_BS_PRMERR;
						else
							bus_stat_reg <= `FBSPI_BS_WAITPRM;
					end
				end
			end
			S_CFG: begin
				// byte 0 input length, byte 1 output length
				if (rx_take) begin
					cnt_reg <= cnt_reg + 8'h01;
					if (cnt_reg == 8'h00)
						cfg_in_reg <= rx_byte_i;
					if (rx_last_i) begin
						st_reg <= S_IDLE;
						if (bus_stat_reg == `FBSPI_BS_PRMERR)
							st_reg <= S_IDLE;
						else if (cnt_reg == 8'h01 &&
						    cfg_in_reg == {in_grps, 3'h0} &&
						    rx_byte_i == {out_grps, 3'h0})
							bus_stat_reg <= `FBSPI_BS_RUN;
						else
							bus_stat_reg <= `FBSPI_BS_CFGERR;
					end
				end
			end
			default: st_reg <= S_IDLE;
			endcase
		end
	end

	// interrupt pacing: fires only with a committed frame pending
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			user_irq_o <= 1'b0;
			irq_ms_reg <= 8'hff;
		end else if (init_pend_reg) begin
			user_irq_o <= 1'b0;
			irq_ms_reg <= 8'hff;
		end else begin
			user_irq_o <= 1'b0;
			if (ms_tick && irq_ms_reg != 8'hff)
				irq_ms_reg <= irq_ms_reg + 8'h01;
			if (irq_pend_reg && !user_irq_o &&
			    (period == 8'h00 || irq_ms_reg >= period)) begin
				user_irq_o <= 1'b1;
				irq_ms_reg <= 8'h00;
			end
		end
	end
endmodule

// [testbench/fbspi_properties.sv]
`timescale 1ns/1ps
// watches the top module's ports for frame, response and irq timing
module fbspi_properties (
	input wire        clock_i,
	input wire        rst_n_i,
	input wire [11:0] paddr_i,
	input wire        psel_i,
	input wire        penable_i,
	input wire        pwrite_i,
	input wire [31:0] pwdata_i,
	input wire        rx_valid_i,
	input wire        rx_last_i,
	input wire [1:0]  rx_kind_i,
	input wire        rx_ready_o,
	input wire        tx_valid_o,
	input wire [7:0]  tx_byte_o,
	input wire        tx_last_o,
	input wire        tx_ready_i,
	input wire [6:0]  station_addr_o,
	input wire        bus_enable_o,
	input wire        user_irq_o,
	input wire        prm_valid_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] tx_cnt_reg;
	logic       got_frame_reg;
	wire        tx_hs   = tx_valid_o && tx_ready_i;
	wire        rx_end  = rx_valid_i && rx_ready_o && rx_last_i
		&& rx_kind_i == 2'h0;
	wire        init_wr = psel_i && penable_i && pwrite_i
		&& paddr_i == 12'h000;
	// byte count per response; set wins over clear so no frame is lost
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_cnt_reg <= 8'h00;
			got_frame_reg <= 1'b0;
		end else begin
			if (tx_hs)
				tx_cnt_reg <= tx_last_o ? 8'h00 : tx_cnt_reg + 8'h01;
			if (rx_end)
				got_frame_reg <= 1'b1;
			else if (user_irq_o)
				got_frame_reg <= 1'b0;
		end
	end
	a_tx_blocks_rx: assert property (tx_valid_o |-> !rx_ready_o)
		else $error("link input open during response");
	a_irq_not_in_tx: assert property (user_irq_o |-> !tx_valid_o)
		else $error("irq before response done");
	a_tx_byte_hold: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_byte_o) && $stable(tx_last_o))
		else $error("response byte not held");
	a_tx_group_end: assert property (tx_hs && tx_last_o |->
		tx_cnt_reg[2:0] == 3'h7)
		else $error("response not whole groups");
	a_irq_one_cycle: assert property (user_irq_o |=> !user_irq_o)
		else $error("irq longer than one cycle");
	a_irq_needs_frame: assert property (user_irq_o |-> got_frame_reg)
		else $error("irq without data frame");
	a_min_delay: assert property (rx_end |=> !tx_valid_o [*8])
		else $error("response too early");
	a_station_load: assert property (init_wr |=>
		station_addr_o == $past(pwdata_i[6:0]))
		else $error("station address not loaded");
	a_init_drops_bus: assert property (init_wr |-> ##2 !bus_enable_o)
		else $error("bus still enabled after init");
	a_prm_needs_bus: assert property (prm_valid_o |-> bus_enable_o)
		else $error("user params valid while bus off");
endmodule

bind fbspi_top fbspi_properties i_fbspi_properties (.clock_i, .rst_n_i,
	.paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .rx_valid_i,
	.rx_last_i, .rx_kind_i, .rx_ready_o, .tx_valid_o, .tx_byte_o,
	.tx_last_o, .tx_ready_i, .station_addr_o, .bus_enable_o, .user_irq_o,
	.prm_valid_o);

// [testbench/fbspi_master_model.sv]
`timescale 1ns/1ps
// stands in for the bus master: sends frames, collects the response
module fbspi_master_model (
	input  wire        clock_i,
	output logic       rx_valid_o,
	output logic [7:0] rx_byte_o,
	output logic       rx_first_o,
	output logic       rx_last_o,
	output logic [1:0] rx_kind_o,
	input  wire        rx_ready_i,
	input  wire        tx_valid_i,
	input  wire [7:0]  tx_byte_i,
	output logic       tx_ready_o
);
	logic [7:0] fr [0:15];
	logic [7:0] rsp [0:255];
	int         rsp_n = 0;
	time        tx_t = 0;
	logic       slow = 1'b0;
	initial begin
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
		rx_first_o = 1'b0;
		rx_last_o = 1'b0;
		rx_kind_o = 2'h0;
		tx_ready_o = 1'b1;
	end
	// slow mode stalls every other cycle, so the design must hold its byte
	always @(posedge clock_i) begin
		tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
		if (tx_valid_i && tx_ready_o) begin
			rsp[rsp_n] <= tx_byte_i;
			rsp_n <= rsp_n + 1;
			tx_t <= $time;
		end
	end
	// each byte held until taken; released line shows the inverse
	task automatic send(input logic [1:0] k, input int n);
		int i;
		@(posedge clock_i);
		for (i = 0; i < n; i++) begin
			rx_valid_o <= 1'b1;
			rx_byte_o <= fr[i];
			rx_first_o <= (i == 0);
			rx_last_o <= (i == n - 1);
			rx_kind_o <= k;
			@(posedge clock_i);
			while (rx_ready_i !== 1'b1)
				@(posedge clock_i);
		end
		rx_valid_o <= 1'b0;
		rx_byte_o <= ~fr[n - 1];
		rx_first_o <= 1'b0;
		rx_last_o <= 1'b0;
	endtask
endmodule

// [testbench/fieldbus_slave_process_image_tb_top.sv]
`timescale 1ns/1ps
module fieldbus_slave_process_image_tb_top;
	typedef struct {
		logic        w;
		logic [11:0] a;
		logic [31:0] d, m, e;
		logic        x;
	} fbspi_row_t;
	logic        clock_i, rst_n_i, psel_i, penable_i, pwrite_i, phy_err_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i;
	wire  [31:0] prdata_o;
	wire         pready_o, pslverr_o, rx_valid_i, rx_first_i, rx_last_i;
	wire         rx_ready_o, tx_valid_o, tx_last_o, tx_ready_i;
	wire         bus_enable_o, user_irq_o, prm_valid_o;
	wire  [7:0]  rx_byte_i, tx_byte_o;
	wire  [1:0]  rx_kind_i;
	wire  [6:0]  station_addr_o;
	int          n_mismatch = 0, total_checks = 0, irq_n = 0, i, k;
	time         irq_t = 0;
	fbspi_row_t  rows [0:16] = '{
		'{0,12'h004,0,32'h1ffff,0,0}, '{0,12'h008,0,32'hff,32'h0b,0},
		'{1,12'h000,32'h0010107e,0,0,0}, '{0,12'h004,0,32'hff,1,0},
		'{1,12'h000,32'h0010f105,0,0,0}, '{0,12'h004,0,32'hff,2,0},
		'{1,12'h000,32'h00f11005,0,0,0}, '{0,12'h004,0,32'hff,2,0},
		'{1,12'h000,32'h000f097d,0,0,0}, '{1,12'h004,0,0,0,1},
		'{0,12'h004,0,32'hffff,32'h1ff,0}, '{0,12'h018,0,0,0,1},
		'{0,12'h101,0,0,0,1},
		'{1,12'h200,32'h03020100,0,0,0}, '{1,12'h204,32'h07060504,0,0,0},
		'{1,12'h208,32'h0b0a0908,0,0,0}, '{1,12'h20c,32'h0f0e0d0c,0,0,0}};

	fbspi_top #(.MS_CYCLES(20)) i_fbspi_top (.clock_i, .rst_n_i, .paddr_i,
		.psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o,
		.pslverr_o, .rx_valid_i, .rx_byte_i, .rx_first_i, .rx_last_i,
		.rx_kind_i, .rx_ready_o, .tx_valid_o, .tx_byte_o, .tx_last_o,
		.tx_ready_i, .phy_err_i, .station_addr_o, .bus_enable_o,
		.user_irq_o, .prm_valid_o);
	fbspi_master_model i_fbspi_master_model (.clock_i,
		.rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
		.rx_first_o(rx_first_i), .rx_last_o(rx_last_i),
		.rx_kind_o(rx_kind_i), .rx_ready_i(rx_ready_o),
		.tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
		.tx_ready_o(tx_ready_i));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	// count irq pulses and keep the time of the latest
	always @(posedge clock_i)
		if (user_irq_o === 1'b1) begin
			irq_n <= irq_n + 1;
			irq_t <= $time;
		end
	task automatic report_and_stop;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	// one apb transfer, then an idle cycle so status has settled
	task automatic acc(input fbspi_row_t r);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= r.w;
		paddr_i <= r.a;
		pwdata_i <= r.d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		@(posedge clock_i);
		while (pready_o !== 1'b1)
			@(posedge clock_i);
		chk("pslverr", {31'h0, r.x}, {31'h0, pslverr_o});
		if (!r.w)
			chk("prdata", r.e, prdata_o & r.m);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
		acc('{1'b0, a, 32'h0, m, e, 1'b0});
	endtask
	// station ident 0x1234 is an arbitrary value; octets 8 on count up
	task automatic prm(input logic [7:0] o1, input int n);
		i_fbspi_master_model.fr[0] = o1;
		i_fbspi_master_model.fr[1] = 8'h01;
		i_fbspi_master_model.fr[2] = 8'h01;
		i_fbspi_master_model.fr[3] = 8'h00;
		i_fbspi_master_model.fr[4] = 8'h12;
		i_fbspi_master_model.fr[5] = 8'h34;
		i_fbspi_master_model.fr[6] = 8'h00;
		for (k = 7; k < 16; k++)
			i_fbspi_master_model.fr[k] = 8'h99 + k;
		i_fbspi_master_model.send(2'h1, n);
	endtask
	task automatic cfg(input logic [7:0] a, b);
		i_fbspi_master_model.fr[0] = a;
		i_fbspi_master_model.fr[1] = b;
		i_fbspi_master_model.send(2'h2, 2);
	endtask
	task automatic data(input logic [7:0] b, input int n);
		for (k = 0; k < n; k++)
			i_fbspi_master_model.fr[k] = b + k;
		i_fbspi_master_model.send(2'h0, n);
	endtask
	task automatic wait_irq(input int n);
		for (k = 0; k < 300 && irq_n < n; k++)
			@(posedge clock_i);
		chk("irq count", n, irq_n);
	endtask
	initial begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		rst_n_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		phy_err_i = 1'b0;
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		for (i = 0; i < 17; i++)
			acc(rows[i]);
		// a data frame before parameters gets no answer
		data(8'h40, 16);
		repeat (60) @(posedge clock_i);
		chk("early rsp", 0, i_fbspi_master_model.rsp_n);
		prm(8'h08, 15);
		rd(12'h008, 32'hffffffff, 32'h0801010b);
		rd(12'h00c, 32'hffff, 32'h1234);
		rd(12'h010, 32'hffffffff, 32'ha3a2a1a0);
		rd(12'h014, 32'hffffffff, 32'ha7a6a5a4);
		rd(12'h004, 32'h1ffff, 32'h001ff);
		cfg(8'h08, 8'h10);
		rd(12'h004, 32'h1ffff, 32'h107ff);
		prm(8'h08, 15);
		cfg(8'h10, 8'h10);
		rd(12'h004, 32'h1ffff, 32'h1ffff);
		// stalled response, then the input image
		i_fbspi_master_model.slow = 1'b1;
		data(8'h40, 16);
		wait_irq(1);
		for (i = 0; i < 16; i++)
			chk("rsp", i, i_fbspi_master_model.rsp[i]);
		chk("irq after rsp", 1, irq_t > i_fbspi_master_model.tx_t);
		rd(12'h100, 32'hffffffff, 32'h43424140);
		rd(12'h108, 32'hffffffff, 32'h4b4a4948);
		rd(12'h10c, 32'hffffffff, 32'h4f4e4d4c);
		data(8'h50, 5);
		wait_irq(2);
		rd(12'h100, 32'hffffffff, 32'h53525150);
		rd(12'h104, 32'hffffffff, 32'h00000054);
		rd(12'h108, 32'hffffffff, 32'h00000000);
		repeat (60) @(posedge clock_i);
		rd(12'h004, 32'h1ffff, 32'h1ffff);
		repeat (100) @(posedge clock_i);
		rd(12'h004, 32'h1ffff, 32'h104ff);
		phy_err_i <= 1'b1;
		@(posedge clock_i);
		rd(12'h004, 32'hff00, 32'h0500);
		phy_err_i <= 1'b0;
		prm(8'h08, 16);
		rd(12'h004, 32'h1ff00, 32'h00800);
		chk("irq total", 2, irq_n);
		// period of 10 ms keeps the second irq pending
		acc('{1'b1, 12'h000, 32'h0a0f097d, 32'h0, 32'h0, 1'b0});
		prm(8'h00, 15);
		cfg(8'h10, 8'h10);
		i_fbspi_master_model.slow = 1'b0;
		data(8'h60, 16);
		data(8'h70, 16);
		repeat (60) @(posedge clock_i);
		chk("irq held", 3, irq_n);
		repeat (250) @(posedge clock_i);
		chk("irq late", 4, irq_n);
		rd(12'h004, 32'h1ffff, 32'h1ffff);
		report_and_stop();
	end
endmodule
